// ### design/spfl_protect.sv
// secondary protection: delay timers, fault/alert flags and pins
`timescale 1ns/1ps

// ----------------------------------------------------------------
// delay timer for one fault source
// ----------------------------------------------------------------
module spfl_delay (
    input wire logic clk_sys, // system clock
    input wire logic rst, // async reset, active high
    input wire logic cond, // live condition, already masked
    input wire logic restart, // host clear restarts the timer
    input wire logic tick, // one-cycle timer tick
    input wire logic [spfl_pkg::DLY_W-1:0] setting, // delay setting
    output logic expire // one-cycle pulse when the delay runs out
);
    typedef struct packed {
        logic [spfl_pkg::CNT_W-1:0] cnt; // elapsed ticks
        logic done; // delay already expired
        logic expire; // expiry pulse
    } spfl_dly_s;

    spfl_dly_s st; // registered state
    spfl_dly_s next_st; // next state
    logic [spfl_pkg::CNT_W-1:0] target; // delay in ticks

    // range bit picks 100 us or 100 ms steps: 100 us up to 12.7 s
    assign target = spfl_pkg::CNT_W'(setting[6:0] *
        (setting[spfl_pkg::RANGE_BIT] ? spfl_pkg::COARSE_TICKS :
        spfl_pkg::FINE_TICKS));

    // count only while the condition stays, restart on any dropout
    always_comb begin
        next_st = st;
        next_st.expire = 1'b0;
        if (restart || !cond) begin
            next_st.cnt = '0;
            next_st.done = 1'b0;
        end else if (!st.done && tick) begin
            // free-running tick phase gives the 0-50 us start deglitch
            if (st.cnt + 1'b1 >= target) begin
                next_st.done = 1'b1;
                next_st.expire = 1'b1;
            end else begin
                next_st.cnt = st.cnt + 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign expire = st.expire;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    chk_dly_restart: assert property (
        !cond |=> st.cnt == '0 && !st.done)
        else $error("delay timer kept counting without its condition");
    chk_dly_expire: assert property (
        expire |-> $past(cond) && !$past(restart))
        else $error("delay expired without a standing condition");
endmodule : spfl_delay

// ----------------------------------------------------------------
// protector top
// ----------------------------------------------------------------
// Operation
// - fault and alert pins driven by hardware alone
// - detected fault sets its matching flag
// - OR flags into summary bits driving pins
// - summary bits and pins latch until cleared
// - three delay timers filter each condition
// - delays programmable 100 us to beyond 3 s
// - zero voltage delay: flag follows live condition
// - write-one clears flag, pin, restarts timer
// - persisting fault reasserts when timer expires again
// - blank comparators 200 us after leaving sleep
// - ignore voltage faults above configured cell count
// - overvoltage past delay sets that cell's flag
// - per-cell overvoltage flags OR into fault bit
// - overvoltage trip points spaced 50 mV
// - timer start passes a 0-50 us deglitch
// - undervoltage past delay sets per-cell flag, ORed
// - thermistor over threshold past delay sets alert
// - temperature threshold: 11 steps plus disabled
// - two thresholds, one shared temperature delay
// - zero temperature delay: flags instant and unlatched
module spfl_protect #(
    parameter int TICK_CYC = spfl_pkg::TICK_CYC, // cycles per tick
    parameter int BLANK_CYC = spfl_pkg::BLANK_CYC // blanking cycles
) (
    input wire logic clk_sys, // system clock, 100 MHz
    input wire logic rst, // async reset, active high
    input wire logic [spfl_pkg::NCELL-1:0] cell_ov_cmp, // ov comparators
    input wire logic [spfl_pkg::NCELL-1:0] cell_uv_cmp, // uv comparators
    input wire logic thermistor_input_1, // temp 1 over threshold
    input wire logic thermistor_input_2, // temp 2 over threshold
    input wire logic sleep_active, // device in sleep state
    input wire logic [spfl_pkg::CNF_W-1:0] cell_count_field, // cells
    input wire logic [spfl_pkg::DLY_W-1:0] ov_delay_setting, // ov delay
    input wire logic [spfl_pkg::DLY_W-1:0] uv_delay_setting, // uv delay
    input wire logic [spfl_pkg::DLY_W-1:0] temp_delay_setting, // shared
    input wire logic [spfl_pkg::THR_W-1:0] ov_threshold_setting, // ov
    input wire logic [spfl_pkg::THR_W-1:0] uv_threshold_setting, // uv
    input wire logic [spfl_pkg::THR_W-1:0] temp1_threshold_setting, // t1
    input wire logic [spfl_pkg::THR_W-1:0] temp2_threshold_setting, // t2
    input wire logic clear_ov, // host write-one to overvoltage bit
    input wire logic clear_uv, // host write-one to undervoltage bit
    input wire logic clear_temp1, // host write-one to temp 1 flag
    input wire logic clear_temp2, // host write-one to temp 2 flag
    output logic [spfl_pkg::NCELL-1:0] per_cell_ov_flags, // per cell
    output logic [spfl_pkg::NCELL-1:0] per_cell_uv_flags, // per cell
    output logic cell_overvoltage, // OR of per-cell ov flags
    output logic cell_undervoltage, // OR of per-cell uv flags
    output logic temp1_alert_flag, // thermistor 1 alert
    output logic temp2_alert_flag, // thermistor 2 alert
    output logic fault_summary, // latched summary fault bit
    output logic alert_summary, // latched summary alert bit
    output logic fault_pin, // fault pin, active high
    output logic alert_pin, // alert pin, active high
    output logic [spfl_pkg::MV_W-1:0] ov_trip_mv, // ov trip point
    output logic [spfl_pkg::MV_W-1:0] uv_trip_mv // uv trip point
);
    localparam int SW = 2 * spfl_pkg::NCELL + 3; // synchronised bits

    typedef struct packed {
        logic [SW-1:0] sync1; // first sync stage, read by sync2 only
        logic [SW-1:0] sync2; // second sync stage
        logic sleep_d; // previous synced sleep level
        logic [14:0] blank_cnt; // blanking countdown
        logic [12:0] tick_cnt; // tick prescaler
        logic tick; // tick pulse
        logic [spfl_pkg::NCELL-1:0] ov_flags; // per-cell ov flags
        logic [spfl_pkg::NCELL-1:0] uv_flags; // per-cell uv flags
        logic ov_any; // OR of per-cell ov flags
        logic uv_any; // OR of per-cell uv flags
        logic [1:0] t_flags; // thermistor alert flags
        logic fault_sum; // summary fault, drives the fault pin
        logic alert_sum; // summary alert, drives the alert pin
        logic [spfl_pkg::MV_W-1:0] ov_mv; // ov trip point
        logic [spfl_pkg::MV_W-1:0] uv_mv; // uv trip point
    } spfl_top_s;

    spfl_top_s st; // registered state
    spfl_top_s next_st; // next state
    logic [spfl_pkg::NCELL-1:0] mask; // cells in use
    logic [spfl_pkg::NCELL-1:0] ov_live; // masked, blanked ov
    logic [spfl_pkg::NCELL-1:0] uv_live; // masked, blanked uv
    logic [1:0] t_live; // gated thermistor conditions
    logic blanking; // comparators suppressed
    logic ov_exp; // ov delay expired
    logic uv_exp; // uv delay expired
    logic t_exp; // shared temperature delay expired
    logic [2:0] ncell; // configured cell count

    // ------------------------------------------------------------
    // condition conditioning
    // ------------------------------------------------------------
    // cell count sits in bits 3:1; seven enables all six cells anyway
    always_comb begin
        ncell = cell_count_field[3:1];
        for (int i = 0; i < spfl_pkg::NCELL; i++) begin
            mask[i] = 3'(i) < ncell;
        end
    end

    // the cycle that sees the wake-up edge is blanked before the count loads
    assign blanking = (st.blank_cnt != '0) ||
                      (st.sleep_d && !st.sync2[SW-1]);

    // blanking hides every comparator, so no false fault on wake-up
    always_comb begin
        ov_live = st.sync2[5:0] & mask & {6{!blanking}};
        uv_live = st.sync2[11:6] & mask & {6{!blanking}};
        // setting zero or beyond the last step reads as disabled
        t_live[0] = st.sync2[12] && !blanking &&
                    temp1_threshold_setting != '0 &&
                    temp1_threshold_setting <= 4'(spfl_pkg::OT_MAX_STEP);
        t_live[1] = st.sync2[13] && !blanking &&
                    temp2_threshold_setting != '0 &&
                    temp2_threshold_setting <= 4'(spfl_pkg::OT_MAX_STEP);
    end

    // ------------------------------------------------------------
    // delay timers: ov, uv, and one shared by both thermistors
    // ------------------------------------------------------------
    spfl_delay u_ov_dly (
        .clk_sys(clk_sys), .rst(rst), .tick(st.tick), .expire(ov_exp),
        .cond(|ov_live), .restart(clear_ov),
        .setting(ov_delay_setting)
    );
    spfl_delay u_uv_dly (
        .clk_sys(clk_sys), .rst(rst), .tick(st.tick), .expire(uv_exp),
        .cond(|uv_live), .restart(clear_uv),
        .setting(uv_delay_setting)
    );
    // both thermistors share one timer and one delay setting
    spfl_delay u_t_dly (
        .clk_sys(clk_sys), .rst(rst), .tick(st.tick), .expire(t_exp),
        .cond(|t_live), .restart(clear_temp1 | clear_temp2),
        .setting(temp_delay_setting)
    );

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        // pins and sleep are asynchronous: two stages before use
        next_st.sync1 = {sleep_active, thermistor_input_2,
                         thermistor_input_1, cell_uv_cmp, cell_ov_cmp};
        next_st.sync2 = st.sync1;
        next_st.sleep_d = st.sync2[SW-1];
        // blanking restarts on each exit from sleep
        if (st.sleep_d && !st.sync2[SW-1]) begin
            next_st.blank_cnt = 15'(BLANK_CYC);
        end else if (blanking) begin
            next_st.blank_cnt = st.blank_cnt - 1'b1;
        end
        // free-running tick; its phase is the start deglitch
        next_st.tick = 1'b0;
        if (st.tick_cnt == 13'(TICK_CYC - 1)) begin
            next_st.tick_cnt = '0;
            next_st.tick = 1'b1;
        end else begin
            next_st.tick_cnt = st.tick_cnt + 1'b1;
        end
        // overvoltage flags: live when delay is zero, else latched
        if (ov_delay_setting == '0) begin
            next_st.ov_flags = ov_live;
        end else begin
            // set beats a clear arriving in the same cycle
            next_st.ov_flags = (st.ov_flags & {6{!clear_ov}}) |
                               (ov_live & {6{ov_exp}});
        end
        // undervoltage flags, same scheme
        if (uv_delay_setting == '0) begin
            next_st.uv_flags = uv_live;
        end else begin
            next_st.uv_flags = (st.uv_flags & {6{!clear_uv}}) |
                               (uv_live & {6{uv_exp}});
        end
        // temperature alerts: instant when shared delay is zero
        if (temp_delay_setting == '0) begin
            next_st.t_flags = t_live;
        end else begin
            next_st.t_flags = (st.t_flags &
                               ~{clear_temp2, clear_temp1}) |
                              (t_live & {2{t_exp}});
        end
        // summary bits stay up until a host clear, then re-derive
        next_st.fault_sum = (st.fault_sum && !clear_ov && !clear_uv) ||
                            (|next_st.ov_flags) ||
                            (|next_st.uv_flags);
        next_st.alert_sum = (st.alert_sum && !clear_temp1 &&
                             !clear_temp2) ||
                            (|next_st.t_flags);
        // group ORs registered so their outputs come from flops
        next_st.ov_any = |next_st.ov_flags;
        next_st.uv_any = |next_st.uv_flags;
        // trip points handed to the analog comparators
        next_st.ov_mv = spfl_pkg::MV_W'(spfl_pkg::OV_BASE_MV +
                        ov_threshold_setting * spfl_pkg::OV_STEP_MV);
        next_st.uv_mv = spfl_pkg::MV_W'(spfl_pkg::UV_BASE_MV +
                        uv_threshold_setting * spfl_pkg::UV_STEP_MV);
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // pins need no host action and no converter: straight from flops
    assign fault_pin = st.fault_sum;
    assign alert_pin = st.alert_sum;
    assign fault_summary = st.fault_sum;
    assign alert_summary = st.alert_sum;
    assign per_cell_ov_flags = st.ov_flags;
    assign per_cell_uv_flags = st.uv_flags;
    assign cell_overvoltage = st.ov_any;
    assign cell_undervoltage = st.uv_any;
    assign temp1_alert_flag = st.t_flags[0];
    assign temp2_alert_flag = st.t_flags[1];
    assign ov_trip_mv = st.ov_mv;
    assign uv_trip_mv = st.uv_mv;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_clear_ov;
        clear_ov && ov_delay_setting != '0 && !ov_exp;
    endsequence
    chk_fault_or: assert property (
        (|st.ov_flags || |st.uv_flags) |-> fault_pin)
        else $error("fault pin low while a voltage flag is set");
    chk_alert_or: assert property (|st.t_flags |-> alert_pin)
        else $error("alert pin low while a temperature flag is set");
    chk_sum_latch: assert property (
        fault_pin && !clear_ov && !clear_uv |=> fault_pin)
        else $error("fault pin dropped without a host clear");
    chk_clear_ov: assert property (s_clear_ov |=> st.ov_flags == '0)
        else $error("overvoltage flags survived a host clear");
    chk_live_ov: assert property (
        ov_delay_setting == '0 |=> st.ov_flags == $past(ov_live))
        else $error("zero-delay overvoltage flags not following comparators");
    chk_live_temp: assert property (
        temp_delay_setting == '0 |=> st.t_flags == $past(t_live))
        else $error("zero-delay temperature flags not following inputs");
    chk_blank_hold: assert property (
        blanking && st.uv_flags == '0 |=> st.uv_flags == '0)
        else $error("undervoltage flag raised during wake-up blanking");
    chk_mask_cells: assert property (
        ov_delay_setting == '0 |=> (st.ov_flags & ~$past(mask)) == '0)
        else $error("overvoltage flag on a cell above the cell count");
    chk_ov_set: assert property (
        ov_exp && ov_delay_setting != '0 |=>
        (st.ov_flags & $past(ov_live)) == $past(ov_live))
        else $error("expired overvoltage timer did not set cell flags");
endmodule : spfl_protect

// ### shared/spfl_pkg.sv
// constants shared by the secondary protection fault logic
package spfl_pkg;
    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int NCELL = 6; // cells watched per device
    localparam int DLY_W = 8; // width of each delay setting
    localparam int CNT_W = 18; // delay counter width, in ticks
    localparam int THR_W = 4; // width of each threshold setting
    localparam int MV_W = 13; // width of a trip point in millivolts
    localparam int CNF_W = 4; // width of the cell count field
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 100; // system clock rate
    localparam int TICK_US = 50; // timer tick, also the start deglitch
    localparam int TICK_CYC = TICK_US * CLK_MHZ; // cycles per tick
    localparam int BLANK_US = 200; // comparator blanking after sleep
    localparam int BLANK_CYC = BLANK_US * CLK_MHZ; // blanking cycles
    localparam int FINE_UNIT_US = 100; // delay step, fine range
    localparam int COARSE_UNIT_US = 100000; // delay step, coarse range
    localparam int FINE_TICKS = FINE_UNIT_US / TICK_US;
    localparam int COARSE_TICKS = COARSE_UNIT_US / TICK_US;
    localparam int RANGE_BIT = 7; // setting bit choosing coarse range
    // ------------------------------------------------------------
    // thresholds
    // ------------------------------------------------------------
    localparam int OT_MAX_STEP = 11; // highest legal temperature step
    localparam int OV_BASE_MV = 2000; // trip point at setting zero
    localparam int OV_STEP_MV = 50; // spacing of overvoltage trip points
    localparam int UV_BASE_MV = 1000; // trip point at setting zero
    localparam int UV_STEP_MV = 50; // spacing of undervoltage points
endpackage : spfl_pkg

// ### testbench/spfl_host_model.sv
// host-side model: write-one-then-zero clears of the fault flags
`timescale 1ns/1ps

// ----------------------------------------------------------------
// host model
// ----------------------------------------------------------------
module spfl_host_model (
    input wire logic clk_sys, // system clock
    input wire logic rst, // async reset, active high
    input wire logic [3:0] clear_req, // ov, uv, temp1, temp2 requests
    output logic clear_ov, // write-one to overvoltage bit
    output logic clear_uv, // write-one to undervoltage bit
    output logic clear_temp1, // write-one to temp 1 flag
    output logic clear_temp2 // write-one to temp 2 flag
);
    // a request held one cycle gives one write of 1, then a write of 0;
    // the bench removes the cause before a clear, except once to show a persisting fault come back
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            clear_ov <= 1'b0;
            clear_uv <= 1'b0;
            clear_temp1 <= 1'b0;
            clear_temp2 <= 1'b0;
        end else begin
            clear_ov <= clear_req[0];
            clear_uv <= clear_req[1];
            clear_temp1 <= clear_req[2];
            clear_temp2 <= clear_req[3];
        end
    end
endmodule : spfl_host_model

// ### testbench/tb_spfl_protect.sv
// testbench for the secondary protection fault logic
`timescale 1ns/1ps

module tb_spfl_protect;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clk_sys = 1'b0; // 100 MHz
    logic rst = 1'b1; // held for 3 cycles
    logic [5:0] cell_ov_cmp = 6'h00, cell_uv_cmp = 6'h00; // comparators
    logic thermistor_input_1 = 1'b0, thermistor_input_2 = 1'b0;
    logic sleep_active = 1'b0; // sleep state
    logic [3:0] cell_count_field = 4'hC; // six cells
    logic [7:0] ov_delay_setting = 8'h02, uv_delay_setting = 8'h00;
    logic [7:0] temp_delay_setting = 8'h01; // shared temp delay
    logic [3:0] ov_threshold_setting = 4'h0, uv_threshold_setting = 4'h0;
    logic [3:0] temp1_threshold_setting = 4'h5;
    logic [3:0] temp2_threshold_setting = 4'h0; // disabled
    logic [3:0] clear_req = 4'h0; // to the host model
    logic clear_ov, clear_uv, clear_temp1, clear_temp2;
    logic [5:0] per_cell_ov_flags, per_cell_uv_flags;
    logic cell_overvoltage, cell_undervoltage, temp1_alert_flag;
    logic temp2_alert_flag, fault_summary, alert_summary;
    logic fault_pin, alert_pin;
    logic [12:0] ov_trip_mv, uv_trip_mv;
    int n_mismatch = 0;
    int comparisons = 0;

    always #5 clk_sys = ~clk_sys;

    // short tick and blanking keep the run brief
    spfl_protect #(.TICK_CYC(10), .BLANK_CYC(20)) dut (.*);
    spfl_host_model host (.clk_sys(clk_sys), .rst(rst),
        .clear_req(clear_req), .clear_ov(clear_ov), .clear_uv(clear_uv),
        .clear_temp1(clear_temp1), .clear_temp2(clear_temp2));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : cyc

    // bounded wait for a flag; running out ends the run
    task automatic wait_set(input int sel, input int lim);
        int i;
        logic v;
        i = 0;
        v = 1'b0;
        while (v !== 1'b1 && i < lim) begin
            @(negedge clk_sys);
            i++;
            case (sel)
                0: v = cell_overvoltage;
                3: v = alert_pin;
                default: v = fault_pin;
            endcase
        end
        check("wait flag", 16'(v), 16'h1);
        if (v !== 1'b1) begin
            stop_test();
        end
    endtask : wait_set

    // one write of 1 then 0 through the host model, then settle
    task automatic clear(input logic [3:0] m);
        @(negedge clk_sys);
        clear_req = m;
        @(negedge clk_sys);
        clear_req = 4'h0;
        cyc(2);
    endtask : clear

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        cyc(3);
        rst = 1'b0;
        cyc(1);
        check("pins after reset", {fault_pin, alert_pin}, 16'h0);
        for (int i = 0; i < 16; i++) begin
            ov_threshold_setting = 4'(i);
            uv_threshold_setting = 4'(i);
            cyc(2);
            check("ov trip", 16'(ov_trip_mv), 16'(2000 + 50 * i));
            check("uv trip", 16'(uv_trip_mv), 16'(spfl_pkg::UV_BASE_MV
                + spfl_pkg::UV_STEP_MV * i));
        end
        // overvoltage with a four-tick delay, latch and clear
        cell_ov_cmp = 6'h01;
        cyc(28);
        check("ov early", cell_overvoltage, 16'h0);
        wait_set(0, 30);
        check("ov cells", per_cell_ov_flags, 16'h01);
        check("fault pins", {fault_summary, fault_pin}, 16'h3);
        cell_ov_cmp = 6'h00;
        cyc(50);
        check("ov latched", {cell_overvoltage, fault_pin}, 16'h3);
        clear(4'h1);
        check("ov cleared", {per_cell_ov_flags, fault_pin}, 16'h0);
        // persisting fault comes back after the restarted delay
        cell_ov_cmp = 6'h04;
        wait_set(0, 60);
        clear(4'h1);
        check("pin after clear", fault_pin, 16'h0);
        cyc(25);
        check("pin held low", fault_pin, 16'h0);
        wait_set(4, 30);
        cell_ov_cmp = 6'h00;
        clear(4'h1);
        // a short dropout restarts the timer from zero
        cell_ov_cmp = 6'h02;
        cyc(20);
        cell_ov_cmp = 6'h00;
        cyc(3);
        cell_ov_cmp = 6'h02;
        cyc(26);
        check("ov after dropout", cell_overvoltage, 16'h0);
        wait_set(0, 30);
        cell_ov_cmp = 6'h00;
        clear(4'h1);
        // four cells configured: cells 5 and 6 ignored
        cell_count_field = 4'h8;
        cell_ov_cmp = 6'h30;
        cyc(80);
        check("unused cells", per_cell_ov_flags, 16'h0);
        cell_ov_cmp = 6'h38;
        wait_set(0, 60);
        check("used cell", per_cell_ov_flags, 16'h08);
        cell_ov_cmp = 6'h00;
        clear(4'h1);
        cell_count_field = 4'hC;
        // undervoltage with zero delay follows the live condition
        cell_uv_cmp = 6'h02;
        cyc(4);
        check("uv live", {per_cell_uv_flags, cell_undervoltage, fault_pin},
              16'h0B);
        cell_uv_cmp = 6'h00;
        cyc(4);
        check("uv gone", per_cell_uv_flags, 16'h0);
        clear(4'h2);
        check("uv clear", fault_pin, 16'h0);
        // temperature: input 2 disabled, input 1 enabled
        thermistor_input_1 = 1'b1;
        thermistor_input_2 = 1'b1;
        cyc(8);
        check("temp early", alert_pin, 16'h0);
        wait_set(3, 20);
        check("temp flags", {temp1_alert_flag, temp2_alert_flag},
              16'h2);
        thermistor_input_1 = 1'b0;
        thermistor_input_2 = 1'b0;
        cyc(30);
        check("temp latched", {alert_summary, alert_pin}, 16'h3);
        clear(4'h4);
        check("temp clear", {temp1_alert_flag, alert_pin}, 16'h0);
        // second input, own threshold, same shared delay
        temp1_threshold_setting = 4'h0;
        temp2_threshold_setting = 4'hB;
        thermistor_input_2 = 1'b1;
        cyc(8);
        check("temp2 early", alert_pin, 16'h0);
        wait_set(3, 20);
        check("temp2 flags", {temp1_alert_flag, temp2_alert_flag},
              16'h1);
        thermistor_input_2 = 1'b0;
        clear(4'h8);
        temp_delay_setting = 8'h00;
        thermistor_input_2 = 1'b1;
        cyc(4);
        check("temp2 live", temp2_alert_flag, 16'h1);
        thermistor_input_2 = 1'b0;
        cyc(4);
        check("temp2 gone", temp2_alert_flag, 16'h0);
        clear(4'h8);
        // comparators blanked right after leaving sleep
        ov_delay_setting = 8'h00;
        sleep_active = 1'b1;
        cyc(5);
        sleep_active = 1'b0;
        cell_ov_cmp = 6'h01;
        cyc(14);
        check("blanked", {cell_overvoltage, fault_pin}, 16'h0);
        wait_set(0, 20);
        cell_ov_cmp = 6'h00;
        cyc(4);
        clear(4'h1);
        // coarse range: 2000 ticks
        ov_delay_setting = 8'h81;
        cell_ov_cmp = 6'h08;
        cyc(19900);
        check("coarse early", cell_overvoltage, 16'h0);
        wait_set(0, 200);
        cell_ov_cmp = 6'h00;
        clear(4'h1);
        check("final pins", {fault_pin, alert_pin}, 16'h0);
        stop_test();
    end
endmodule : tb_spfl_protect
